// >>> rtl/acmc_defs.vh
/*
 * constants for the audio clock mode control block: word layout, defaults,
 * frequency group codes and reset timing.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef ACMC_DEFS_VH
`define ACMC_DEFS_VH

// ****************************************
// control word layout
// ****************************************
`define ACMC_WORD_BITS      16
`define ACMC_GROUP_LSB      0
`define ACMC_GROUP_MSB      1
`define ACMC_RATE_BIT       2
`define ACMC_RSV_BIT        3
`define ACMC_EN_LSB         4
`define ACMC_EN_MSB         9
`define ACMC_EN_BITS        6

// ****************************************
// field encodings and defaults
// ****************************************
`define ACMC_GROUP_48K      2'h0
`define ACMC_GROUP_44K1     2'h1
`define ACMC_GROUP_32K      2'h2
`define ACMC_GROUP_RSV      2'h3
`define ACMC_RATE_STD       1'b0
`define ACMC_RATE_DBL       1'b1
`define ACMC_EN_ALL_ON      6'h3F
`define ACMC_EN_ALL_OFF     6'h00

// ****************************************
// reset and timing
// ****************************************
`define ACMC_POR_CYCLES     11'h400
`define ACMC_POR_LAST       11'h3FF
`define ACMC_BIT_CNT_FULL   5'h10
`define ACMC_POR_CNT_BITS   11
`define ACMC_BIT_CNT_BITS   5

`endif

// >>> rtl/acmc_sync2.v
/*
 * two flip-flop level synchroniser for one pin.
 * assumes the pin is asynchronous to clk_in; reset value is low.
 */
`timescale 1ns/100ps
module acmc_sync2 (
	// clock and reset
	input  wire clk_in,
	input  wire rst_in,
	// pin and synchronised level
	input  wire async_in,
	output wire sync_out
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// >>> rtl/acmc_mode_ctrl.v
/*
 * mode control of a dual-PLL audio clock generator: parallel pin decode
 * and a three-wire serial control word receiver with power-down.
 * assumes the serial bit clock is slow (period 320 ns in the bench) next
 * to ref_clk_in; pins are sampled through two flip-flops.
 * assumes serial_mode_in is a board strap held steady from reset onward;
 * a word shifted before the strap is taken in is lost.
 */
`timescale 1ns/100ps
`include "acmc_defs.vh"

module acmc_mode_ctrl (
	// clock and reset
	input  wire       ref_clk_in,
	input  wire       rst_in,
	// variant strap: high selects the serial variant
	input  wire       serial_mode_in,
	// shared control pins
	input  wire       rate_select_in,
	input  wire       group_select_lo_in,
	input  wire       group_select_hi_in,
	// decoded mode
	output reg  [1:0] freq_group_out,
	output reg        group_reserved_out,
	output reg        double_rate_out,
	// output enables
	output reg        en_sys_clk0_out,
	output reg        en_sys_clk1_out,
	output reg        en_sys_clk2_out,
	output reg        en_sys_clk3_out,
	output reg        en_master_out1_out,
	output reg        en_master_out2_out,
	// power state
	output reg        power_down_out,
	output reg        init_done_out
);
	// in serial mode the pins carry latch, bit clock and data
	wire                          latch_strobe_s;
	wire                          serial_bit_clock_s;
	wire                          serial_data_in_s;
	reg                           bclk_prev_q;
	reg                           latch_prev_q;
	reg  [`ACMC_WORD_BITS-1:0]    shift_q;
	reg  [`ACMC_BIT_CNT_BITS-1:0] bit_cnt_q;
	reg  [1:0]                    group_q;
	reg                           rate_q;
	reg  [`ACMC_EN_BITS-1:0]      en_q;
	reg  [`ACMC_POR_CNT_BITS-1:0] por_cnt_q;
	reg                           strap_q;
	wire                          bclk_rise;
	wire                          latch_rise;
	wire [2:0]                    pin_async;
	wire [2:0]                    pin_sync;
	reg                           init_state_q;
	reg  [1:0]                    group_sel;
	reg                           rate_sel;
	reg  [`ACMC_EN_BITS-1:0]      en_sel;

	// init sequence states
	localparam ST_INIT = 1'b0;
	localparam ST_RUN  = 1'b1;

	// place of each output enable inside the enable field
	localparam EN_SYS0    = 0;
	localparam EN_SYS2    = 1;
	localparam EN_SYS3    = 2;
	localparam EN_SYS1    = 3;
	localparam EN_MASTER1 = 4;
	localparam EN_MASTER2 = 5;

	function is_reserved_group;
		input [1:0] code;
		begin
			is_reserved_group = (code == `ACMC_GROUP_RSV);
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	// one synchroniser per shared pin serves both variants
	assign pin_async = {rate_select_in, group_select_hi_in, group_select_lo_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			acmc_sync2 acmc_sync2_i (
				.clk_in   (ref_clk_in),
				.rst_in   (rst_in),
				.async_in (pin_async[gi]),
				.sync_out (pin_sync[gi])
			);
		end
	endgenerate
	assign latch_strobe_s     = pin_sync[2];
	assign serial_bit_clock_s = pin_sync[1];
	assign serial_data_in_s   = pin_sync[0];

	assign bclk_rise  = serial_bit_clock_s & ~bclk_prev_q;
	assign latch_rise = latch_strobe_s & ~latch_prev_q;

	// ****************************************
	// strap capture and power-on count
	// ****************************************
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			init_state_q <= ST_INIT;
			por_cnt_q    <= {`ACMC_POR_CNT_BITS{1'b0}};
			strap_q      <= 1'b0;
		end else begin
			case (init_state_q)
				ST_INIT: begin
					// the strap is held for the whole init window; last sample wins
					por_cnt_q <= por_cnt_q + 1'b1;
					strap_q   <= serial_mode_in;
					if (por_cnt_q == `ACMC_POR_LAST)
						init_state_q <= ST_RUN;
				end
				ST_RUN: begin
					// the count parks at its end value
					por_cnt_q <= por_cnt_q;
				end
				default: begin
					init_state_q <= ST_INIT;
				end
			endcase
		end
	end

	// ****************************************
	// serial receiver
	// ****************************************
	// keeps running in power-down so a new word can wake the block
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bclk_prev_q  <= 1'b0;
			latch_prev_q <= 1'b0;
			shift_q      <= {`ACMC_WORD_BITS{1'b0}};
			bit_cnt_q    <= {`ACMC_BIT_CNT_BITS{1'b0}};
			group_q      <= `ACMC_GROUP_48K;
			rate_q       <= `ACMC_RATE_STD;
			en_q         <= `ACMC_EN_ALL_ON;
		end else begin
			bclk_prev_q  <= serial_bit_clock_s;
			latch_prev_q <= latch_strobe_s;
			if (strap_q) begin
				if (bclk_rise) begin
					// msb first, the last bit lands in bit 0
					shift_q <= {shift_q[`ACMC_WORD_BITS-2:0], serial_data_in_s};
					// saturate so an over-long word keeps only its last sixteen bits
					if (bit_cnt_q != `ACMC_BIT_CNT_FULL)
						bit_cnt_q <= bit_cnt_q + 1'b1;
				end
				// no timeout: the word waits for the strobe indefinitely
				if (latch_rise) begin
					bit_cnt_q <= {`ACMC_BIT_CNT_BITS{1'b0}};
					// a short word (fewer than sixteen bit clock rises before the strobe rise) is dropped
					if (bit_cnt_q == `ACMC_BIT_CNT_FULL) begin
						group_q <= shift_q[`ACMC_GROUP_MSB:`ACMC_GROUP_LSB];
						rate_q  <= shift_q[`ACMC_RATE_BIT];
						en_q    <= shift_q[`ACMC_EN_MSB:`ACMC_EN_LSB];
					end
				end
			end
		end
	end

	// ****************************************
	// mode selection and output registers
	// ****************************************
	// parallel mode has no enables of its own, so it never powers down
	always @* begin
		if (strap_q) begin
			group_sel = group_q;
			rate_sel  = rate_q;
			en_sel    = en_q;
		end else begin
			group_sel = {serial_bit_clock_s, serial_data_in_s};
			rate_sel  = latch_strobe_s;
			en_sel    = `ACMC_EN_ALL_ON;
		end
	end

	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			freq_group_out     <= `ACMC_GROUP_48K;
			group_reserved_out <= 1'b0;
			double_rate_out    <= `ACMC_RATE_STD;
			en_sys_clk0_out    <= 1'b1;
			en_sys_clk1_out    <= 1'b1;
			en_sys_clk2_out    <= 1'b1;
			en_sys_clk3_out    <= 1'b1;
			en_master_out1_out <= 1'b1;
			en_master_out2_out <= 1'b1;
			power_down_out     <= 1'b0;
			init_done_out      <= 1'b0;
		end else begin
			freq_group_out     <= group_sel;
			group_reserved_out <= is_reserved_group(group_sel);
			double_rate_out    <= rate_sel;
			en_sys_clk0_out    <= en_sel[EN_SYS0];
			en_sys_clk2_out    <= en_sel[EN_SYS2];
			en_sys_clk3_out    <= en_sel[EN_SYS3];
			en_sys_clk1_out    <= en_sel[EN_SYS1];
			en_master_out1_out <= en_sel[EN_MASTER1];
			en_master_out2_out <= en_sel[EN_MASTER2];
			// follows the enables, so any accepted word with one enable bit set wakes the block
			power_down_out     <= (en_sel == `ACMC_EN_ALL_OFF);
			init_done_out      <= (por_cnt_q == `ACMC_POR_CYCLES);
		end
	end
endmodule

// >>> test/acmc_monitor.sv
/* port checker for acmc_mode_ctrl.
   assumes a bind by port name. */
`timescale 1ns/100ps
module acmc_monitor (
	// clock, reset, pins
	input wire       ref_clk_in,
	input wire       rst_in,
	input wire       serial_mode_in,
	input wire       rate_select_in,
	input wire       group_select_lo_in,
	input wire       group_select_hi_in,
	// mode outputs
	input wire [1:0] freq_group_out,
	input wire       group_reserved_out,
	input wire       double_rate_out,
	input wire       en_sys_clk0_out,
	input wire       en_sys_clk1_out,
	input wire       en_sys_clk2_out,
	input wire       en_sys_clk3_out,
	input wire       en_master_out1_out,
	input wire       en_master_out2_out,
	input wire       power_down_out,
	input wire       init_done_out
);
	// ****
	// checks
	// ****
	wire [5:0] en = {en_master_out2_out, en_master_out1_out, en_sys_clk1_out,
		en_sys_clk3_out, en_sys_clk2_out, en_sys_clk0_out};
	wire       par = !serial_mode_in && init_done_out;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	chk_par_group: assert property (par |-> freq_group_out == $past({group_select_hi_in, group_select_lo_in}, 3))
		else $error("group pins");
	chk_par_rate: assert property (par |-> double_rate_out == $past(rate_select_in, 3))
		else $error("rate pin");
	chk_par_enable: assert property (par |-> en == 6'h3F && !power_down_out)
		else $error("parallel enables");
	chk_rsv_flag: assert property (group_reserved_out == (freq_group_out == 2'h3))
		else $error("reserved flag");
	chk_pd_all_off: assert property (power_down_out == (en == 6'h00))
		else $error("power down");
	// a serial word may only land a few clocks after a latch rise
	chk_latch_only: assert property (serial_mode_in && $past(init_done_out, 6) && $changed({en, double_rate_out, freq_group_out})
		|-> $past(rate_select_in, 3) && !$past(rate_select_in, 6))
		else $error("change without latch");
	chk_reset_dflt: assert property (disable iff (1'b0) rst_in |-> freq_group_out == 2'h0 && !double_rate_out
		&& en == 6'h3F && !power_down_out && !init_done_out) else $error("reset value");
	chk_init_stays: assert property (init_done_out |=> init_done_out)
		else $error("init drop");
	cover property ($rose(power_down_out));
	cover property (serial_mode_in && group_reserved_out);
	cover property (par && double_rate_out);
endmodule

// >>> test/acmc_ser_host.sv
/* serial controller model for the three-wire pins.
   assumes pins with internal pull-downs. */
`timescale 1ns/100ps
module acmc_ser_host (
	// three-wire control
	output logic serial_bit_clock_out,
	output logic serial_data_out,
	output logic latch_strobe_out
);
	initial begin
		serial_bit_clock_out = 1'b0;
		serial_data_out = 1'b0;
		latch_strobe_out = 1'b0;
	end
	// bit clock stands low between frames
	task automatic send(input logic [15:0] w, input int n, input int gap_ns);
		latch_strobe_out = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_out = w[i % 16];
			#160 serial_bit_clock_out = 1'b1;
			#160 serial_bit_clock_out = 1'b0;
		end
		serial_data_out = 1'b0;
		#(gap_ns) latch_strobe_out = 1'b1;
		#400;
	endtask
endmodule

// >>> test/tb_acmc_mode_ctrl.sv
/* self-checking bench for acmc_mode_ctrl, both variants.
   assumes the serial host model and the port checker. */
`timescale 1ns/100ps
module tb_acmc_mode_ctrl;
	// clock starts high so reset is applied on the first falling edge
	logic        ref_clk_in = 1'b1;
	logic        rst_in = 1'b0;
	logic        serial_mode_in = 1'b0;
	logic [2:0]  par_q = 3'h0;
	logic [15:0] last_q = 16'h73F0;
	wire         bclk, sdat, latch, reserved_zero_bit, dbl, pd, done;
	wire [1:0]   grp;
	wire [5:0]   en;
	wire [10:0]  obs = {pd, reserved_zero_bit, en, dbl, grp};
	int          n_errors = 0;
	int          num_checks = 0;
	acmc_ser_host acmc_ser_host_i (.serial_bit_clock_out(bclk), .serial_data_out(sdat), .latch_strobe_out(latch));
	acmc_mode_ctrl acmc_mode_ctrl_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_mode_in(serial_mode_in),
		.rate_select_in(serial_mode_in ? latch : par_q[2]), .group_select_lo_in(serial_mode_in ? sdat : par_q[0]),
		.group_select_hi_in(serial_mode_in ? bclk : par_q[1]), .freq_group_out(grp), .group_reserved_out(reserved_zero_bit),
		.double_rate_out(dbl), .en_sys_clk0_out(en[0]), .en_sys_clk2_out(en[1]), .en_sys_clk3_out(en[2]),
		.en_sys_clk1_out(en[3]), .en_master_out1_out(en[4]), .en_master_out2_out(en[5]),
		.power_down_out(pd), .init_done_out(done));
	function automatic logic [10:0] exp_of(input logic [15:0] w);
		return {w[9:4] == 6'h00, w[1:0] == 2'h3, w[9:4], w[2:0]};
	endfunction
	task automatic check(input logic [10:0] seen, input logic [10:0] want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset(input logic serial);
		@(negedge ref_clk_in);
		rst_in = 1'b1;
		serial_mode_in = serial;
		repeat (2) @(negedge ref_clk_in);
		check(obs, exp_of(16'h73F0));
		rst_in = 1'b0;
		for (int i = 0; i < 1100 && done !== 1'b1; i++)
			@(negedge ref_clk_in);
		check({10'h000, done}, 11'h001);
	endtask
	task automatic t_parallel();
		for (int i = 0; i < 8; i++) begin
			par_q = i[2:0];
			repeat (4) @(negedge ref_clk_in);
			check(obs, exp_of({6'h00, 6'h3F, 1'b0, par_q}));
		end
	endtask
	// a short word must leave the last accepted one in place; a long one keeps its last sixteen bits
	task automatic t_send(input logic [5:0] e, input logic [2:0] rg, input int n, input int gap);
		logic [15:0] w;
		w = {6'h1C, e, 1'b0, rg};
		acmc_ser_host_i.send(w, n, gap);
		if (n >= 16)
			last_q = w;
		@(negedge ref_clk_in);
		check(obs, exp_of(last_q));
	endtask
	initial begin
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		#1000000;
		n_errors++;
		stop_test();
	end
	initial begin
		do_reset(1'b0);
		t_parallel();
		do_reset(1'b1);
		for (int i = 0; i < 6; i++)
			t_send(6'h01 << i, {i[0], i[1:0]}, 16, 0);
		t_send(6'h00, 3'h5, 16, 0);
		t_send(6'h20, 3'h2, 16, 5000);
		t_send(6'h15, 3'h1, 17, 0);
		t_send(6'h3F, 3'h6, 15, 0);
		stop_test();
	end
endmodule
bind acmc_mode_ctrl acmc_monitor acmc_monitor_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
	.serial_mode_in(serial_mode_in), .rate_select_in(rate_select_in), .group_select_lo_in(group_select_lo_in),
	.group_select_hi_in(group_select_hi_in), .freq_group_out(freq_group_out), .group_reserved_out(group_reserved_out),
	.double_rate_out(double_rate_out), .en_sys_clk0_out(en_sys_clk0_out), .en_sys_clk1_out(en_sys_clk1_out),
	.en_sys_clk2_out(en_sys_clk2_out), .en_sys_clk3_out(en_sys_clk3_out), .en_master_out1_out(en_master_out1_out),
	.en_master_out2_out(en_master_out2_out), .power_down_out(power_down_out), .init_done_out(init_done_out));
